// ===== demc_assertions.sv
// Checker for the stream and serial ports.
// Bound into the block; one ref_clk domain.
`default_nettype none
module demc_assertions #(
   parameter int WORD_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic serial_result_line_first,
   input wire logic serial_result_line_second,
   input wire logic register_mode,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [WORD_W-1:0] parallel_bus_word,
   input wire logic parallel_valid,
   input wire logic parallel_ready
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // --------------------
   // Stream buffer
   // --------------------
   a_word_hold: assert property (parallel_valid && !parallel_ready |=> parallel_valid && $stable(parallel_bus_word))
      else $error("word moved in stall");
   a_valid_drop: assert property ($fell(parallel_valid) |-> $past(parallel_ready))
      else $error("valid dropped");
   a_push_answer: assert property (sample_valid && sample_ready && !parallel_valid |=> parallel_valid)
      else $error("push not shown");
   a_full_refuse: assert property (!sample_ready && !parallel_ready |=> !sample_ready)
      else $error("full buffer took word");
   a_full_cause: assert property ($fell(sample_ready) |-> $past(sample_valid) && parallel_valid)
      else $error("full without push");
   // --------------------
   // Serial lines
   // --------------------
   a_line_two_off: assert property (register_mode && $past(register_mode) |-> !serial_result_line_second)
      else $error("line two in register mode");
   a_idle_low: assert property (spi_cs_n [*5] |-> !serial_result_line_first && !serial_result_line_second)
      else $error("line high when idle");
   a_bit_stands: assert property ($changed(serial_result_line_first) |-> spi_sclk)
      else $error("bit moved, clock low");
   a_mode_quiet: assert property ($changed(register_mode) |-> spi_cs_n)
      else $error("mode moved in frame");
   c_full: cover property (!sample_ready);
   c_reg: cover property ($rose(register_mode));
   c_stall: cover property (parallel_valid && !parallel_ready);
endmodule
bind diag_error_monitor_crc demc_assertions #(.WORD_W(WORD_W)) u_chk (.ref_clk, .rst, .spi_sclk, .spi_cs_n,
   .serial_result_line_first, .serial_result_line_second, .register_mode, .sample_valid, .sample_ready,
   .parallel_bus_word, .parallel_valid, .parallel_ready);
`default_nettype wire

// ===== demc_host.sv
// Host model: serial master for register frames.
// Assumes the device samples SDI on SCLK falling.
`default_nettype none
module demc_host (
   input wire logic ref_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   logic crc_on;
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      crc_on = 1'b0;
   end
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction
   // --------------------
   // Frame: clock low 3, high 5 cycles; stands high between frames
   // --------------------
   task automatic frame(input logic [15:0] w, input logic bad, output logic [23:0] rx);
      logic [23:0] tx;
      int n;
      tx = crc_on ? {w, crc8(w) ^ {8{bad}}} : {8'h00, w};
      n = crc_on ? 24 : 16;
      rx = '0;
      @(posedge ref_clk);
      spi_cs_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (int i = n - 1; i >= 0; i--) begin
         spi_sdi <= tx[i];
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         rx = {rx[22:0], sdo};
         @(posedge ref_clk);
         spi_sclk <= 1'b0;
         repeat (3) @(posedge ref_clk);
         spi_sclk <= 1'b1;
         @(posedge ref_clk);
      end
      spi_sdi <= ~tx[0];
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic bad);
      logic [23:0] rx;
      frame({2'b00, a, d}, bad, rx);
   endtask
   // Second frame starts with a 1, so the device ignores it
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [7:0] c);
      logic [23:0] rx;
      frame({2'b01, a, 8'h00}, 1'b0, rx);
      frame(16'hFFFF, 1'b0, rx);
      d = crc_on ? rx[15:8] : rx[7:0];
      c = rx[7:0];
   endtask
endmodule
`default_nettype wire

// ===== demc_pkg.sv
// Constants, register map and CRC helpers for the diagnostics block.
// Assumes one 50 MHz clock domain; all users import the whole package.
`default_nettype none
package demc_pkg;
   // --------------------
   // Register map
   // --------------------
   localparam logic [5:0] ADDR_EXIT = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h01;
   localparam logic [5:0] ADDR_MON_EN = 6'h21;
   localparam logic [5:0] ADDR_MON_ERR = 6'h22;
   localparam logic [5:0] ADDR_LIM_EN = 6'h25;
   localparam logic [5:0] ADDR_OVER = 6'h26;
   localparam logic [5:0] ADDR_UNDER = 6'h27;
   localparam int ST_RESET_BIT = 7;
   localparam int ST_DIGITAL_BIT = 6;
   localparam int MON_ROM_BIT = 0;
   localparam int MON_MM_BIT = 1;
   localparam int MON_INTF_BIT = 2;
   localparam logic [7:0] MON_EN_RESET = 8'h01;
   localparam logic [7:0] LIM_EN_RESET = 8'h00;
   localparam logic [7:0] MON_IMPL_MASK = 8'h3F;
   // --------------------
   // Frame layout and CRC polynomials
   // --------------------
   localparam int CHANNELS = 8;
   localparam int SAMPLE_BITS = 16;
   localparam int HEADER_BITS = 8;
   localparam int CMD_BITS = 16;
   localparam int CRC16_BITS = 16;
   localparam int CRC8_BITS = 8;
   localparam int RX_CRC_BITS = CMD_BITS + CRC8_BITS;
   localparam logic [15:0] POLY16 = 16'h755B;
   localparam logic [7:0] POLY8 = 8'h07;
   // --------------------
   // Timing
   // --------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int MM_PERIOD_NS = 4000;
   localparam int MM_CYCLES = MM_PERIOD_NS / CLK_PERIOD_NS;
   // --------------------
   // Factory trim store; contents arbitrary
   // --------------------
   localparam int TRIM_WORDS = 4;
   localparam logic [7:0] TRIM_ROM [TRIM_WORDS] = '{8'h3C, 8'hA5, 8'h0F, 8'h96};

   typedef enum logic [1:0] {
      DEMC_DRAIN_DATA = 2'b00,
      DEMC_DRAIN_CRC = 2'b01
   } demc_drain_type;

   typedef enum logic [1:0] {
      DEMC_TX_DATA = 2'b00,
      DEMC_TX_CRC = 2'b01,
      DEMC_TX_DONE = 2'b10
   } demc_tx_type;

   // MSB-first division, zero init: same as appending zeros and dividing
   function automatic logic [15:0] crc16_bits(input logic [15:0] crc, input logic [15:0] data, input int nbits);
      logic [15:0] c;
      c = crc;
      for (int i = 0; i < 16; i++) begin
         if (i < nbits) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ data[15 - i]) ? POLY16 : 16'h0000);
         end
      end
      return c;
   endfunction

   function automatic logic [7:0] crc8_word(input logic [15:0] data);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ data[i]) ? POLY8 : 8'h00);
      end
      return c;
   endfunction

   function automatic logic [15:0] trim_crc();
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < TRIM_WORDS; i++) begin
         c = crc16_bits(c, {TRIM_ROM[i], 8'h00}, 8);
      end
      return c;
   endfunction

   localparam logic [15:0] ROM_CRC = trim_crc();
endpackage
`default_nettype wire

// ===== diag_error_monitor_crc.sv
// Self-diagnostics of an 8-channel sampling converter: reset flag, input
// limit flags, digital fault summary, trim and register-map CRC checks,
// interface CRC on serial and parallel readout.
// Assumes: serial pins asynchronous to ref_clk, SCLK idles high and runs at
// most ref_clk/8; sample stream and fault pulses are on ref_clk.
//
// Contract
// - Any reset sets reset-detected status bit
// - Only status register read clears it
// - Limit-check enable register gates comparators
// - Over-limit sets channel bit in 0x26
// - Under-limit sets channel bit in 0x27
// - Limit flags sticky; write-one or disable clears
// - Any monitor fault raises digital-error bit
// - Each monitor has own fault detail bit
// - Trim load CRC mismatch sets bit 0
// - Trim check on from reset; enable bit 0
// - Map CRC off at reset; enable stores reference
// - Map CRC rechecked every 4 us
// - Every map write refreshes stored reference
// - Map CRC uses given 16-bit polynomial
// - Serial lines append 16-bit CRC word
// - CRC is remainder after zero-appended division
// - Two lines four channels; one line eight
// - Register frames 24 bits, CRC8 bits 17-24
// - Write CRC8 mismatch sets fault bit 2
// - Parallel bus appends CRC after channel 8
// - Status header byte follows each sample on the serial lines
`default_nettype none
module diag_error_monitor_crc
   import demc_pkg::*;
#(
   parameter int WORD_W = 16,
   parameter int BUF_DEPTH = 2,
   parameter logic [15:0] ROM_STORED_CRC = ROM_CRC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic partial_reset_in,
   input wire logic [7:0] over_limit_in,
   input wire logic [7:0] under_limit_in,
   input wire logic [2:0] ext_fault_pulse,
   input wire logic status_header_on,
   input wire logic serial_two_lines,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic serial_result_line_first,
   output logic serial_result_line_second,
   output logic register_mode,
   input wire logic [WORD_W-1:0] sample_word,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic [WORD_W-1:0] parallel_bus_word,
   output logic parallel_valid,
   input wire logic parallel_ready
);
   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CNT_W = $clog2(BUF_DEPTH + 1);
   localparam logic [19:0] PIN_IDLE = 20'h00006;

   // --------------------
   // Pin synchronisers
   // --------------------
   logic [19:0] pin_meta_r, pin_sync_r;
   logic [2:0] edge_prev_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_meta_r <= PIN_IDLE;
         pin_sync_r <= PIN_IDLE;
         edge_prev_r <= 3'h3;
      end else begin
         pin_meta_r <= {partial_reset_in, over_limit_in, under_limit_in, spi_sclk, spi_cs_n, spi_sdi};
         pin_sync_r <= pin_meta_r;
         edge_prev_r <= {pin_sync_r[19], pin_sync_r[2], pin_sync_r[1]};
      end
   end
   logic [7:0] over_s, under_s;
   logic partial_rise, sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame;
   assign over_s = pin_sync_r[18:11];
   assign under_s = pin_sync_r[10:3];
   assign partial_rise = pin_sync_r[19] & ~edge_prev_r[2];
   assign sclk_rise = pin_sync_r[2] & ~edge_prev_r[1];
   assign sclk_fall = ~pin_sync_r[2] & edge_prev_r[1];
   assign cs_fall = ~pin_sync_r[1] & edge_prev_r[0];
   assign cs_rise = pin_sync_r[1] & ~edge_prev_r[0];
   assign in_frame = ~pin_sync_r[1];

   // --------------------
   // Registers and command decode
   // --------------------
   logic rst_det_r, reg_mode_r, wr_d_r, mm_en_d_r;
   logic [5:0] rd_addr_r;
   logic [7:0] mon_en_r, lim_en_r, mon_err_r, over_r, under_r;
   logic [23:0] rx_shift_r;
   logic [4:0] rx_cnt_r;
   logic [15:0] cmd;
   logic [7:0] rx_crc, rd_data, w1c_err, w1c_over, w1c_under;
   logic crc_on, cmd_ok, crc_ok, wr_fire, rd_fire, intf_fail, status_read;
   logic digital_error;

   assign crc_on = mon_en_r[MON_INTF_BIT];
   assign cmd = crc_on ? rx_shift_r[23:8] : rx_shift_r[15:0];
   assign rx_crc = rx_shift_r[7:0];
   assign cmd_ok = cs_rise & ~cmd[15] & (rx_cnt_r >= 5'(crc_on ? RX_CRC_BITS : CMD_BITS));
   assign crc_ok = ~crc_on | (crc8_word(cmd) == rx_crc);
   assign rd_fire = cmd_ok & cmd[14];
   assign wr_fire = cmd_ok & ~cmd[14] & crc_ok;
   assign intf_fail = cmd_ok & ~cmd[14] & ~crc_ok;
   assign w1c_err = (wr_fire && cmd[13:8] == ADDR_MON_ERR) ? cmd[7:0] : 8'h00;
   assign w1c_over = (wr_fire && cmd[13:8] == ADDR_OVER) ? cmd[7:0] : 8'h00;
   assign w1c_under = (wr_fire && cmd[13:8] == ADDR_UNDER) ? cmd[7:0] : 8'h00;
   assign digital_error = |mon_err_r;
   assign register_mode = reg_mode_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_shift_r <= 24'h000000;
         rx_cnt_r <= 5'h00;
      end else if (cs_fall) begin
         rx_cnt_r <= 5'h00;
      end else if (in_frame && sclk_fall && rx_cnt_r < 5'(RX_CRC_BITS)) begin
         rx_shift_r <= {rx_shift_r[22:0], pin_sync_r[0]};
         rx_cnt_r <= rx_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_mode_r <= 1'b0;
         rd_addr_r <= ADDR_EXIT;
      end else if (rd_fire) begin
         reg_mode_r <= 1'b1;
         rd_addr_r <= cmd[13:8];
      end else if (wr_fire && cmd[13:8] == ADDR_EXIT) begin
         reg_mode_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mon_en_r <= MON_EN_RESET;
         lim_en_r <= LIM_EN_RESET;
      end else if (wr_fire && cmd[13:8] == ADDR_MON_EN) begin
         mon_en_r <= cmd[7:0];
      end else if (wr_fire && cmd[13:8] == ADDR_LIM_EN) begin
         lim_en_r <= cmd[7:0];
      end
   end

   always_comb begin
      if (rd_addr_r == ADDR_STATUS) begin
         rd_data = {rst_det_r, digital_error, 6'h00};
      end else if (rd_addr_r == ADDR_MON_EN) begin
         rd_data = mon_en_r;
      end else if (rd_addr_r == ADDR_MON_ERR) begin
         rd_data = mon_err_r;
      end else if (rd_addr_r == ADDR_LIM_EN) begin
         rd_data = lim_en_r;
      end else if (rd_addr_r == ADDR_OVER) begin
         rd_data = over_r;
      end else if (rd_addr_r == ADDR_UNDER) begin
         rd_data = under_r;
      end else begin
         rd_data = 8'h00;
      end
   end

   // --------------------
   // Reset flag and input limit flags
   // --------------------
   assign status_read = cs_fall & reg_mode_r & (rd_addr_r == ADDR_STATUS);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_det_r <= 1'b1;
      end else if (partial_rise) begin
         rst_det_r <= 1'b1;
      end else if (status_read) begin
         rst_det_r <= 1'b0;
      end
   end

   // Set beats write-one-clear; disable beats everything
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         over_r <= 8'h00;
         under_r <= 8'h00;
      end else begin
         over_r <= ((over_r & ~w1c_over) | over_s) & lim_en_r;
         under_r <= ((under_r & ~w1c_under) | under_s) & lim_en_r;
      end
   end

   // --------------------
   // Trim load check and register-map CRC
   // --------------------
   logic [7:0] trim_r [TRIM_WORDS];
   logic [2:0] rom_idx_r;
   logic rom_done_r, rom_check, rom_fail, mm_store, mm_tick, mm_fail;
   logic [15:0] rom_calc, mm_now, mm_ref_r;
   logic [7:0] mm_tmr_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rom_idx_r <= 3'h0;
         rom_done_r <= 1'b0;
         for (int i = 0; i < TRIM_WORDS; i++) begin
            trim_r[i] <= 8'h00;
         end
      end else begin
         if (rom_idx_r < 3'(TRIM_WORDS)) begin
            trim_r[rom_idx_r[1:0]] <= TRIM_ROM[rom_idx_r[1:0]];
            rom_idx_r <= rom_idx_r + 3'h1;
         end
         rom_done_r <= rom_done_r | rom_check;
      end
   end
   always_comb begin
      rom_calc = 16'h0000;
      for (int i = 0; i < TRIM_WORDS; i++) begin
         rom_calc = crc16_bits(rom_calc, {trim_r[i], 8'h00}, 8);
      end
   end
   assign rom_check = (rom_idx_r == 3'(TRIM_WORDS)) & ~rom_done_r;
   assign rom_fail = rom_check & (rom_calc != ROM_STORED_CRC);

   assign mm_now = crc16_bits(16'h0000, {mon_en_r, lim_en_r}, 16);
   assign mm_store = mon_en_r[MON_MM_BIT] & (~mm_en_d_r | wr_d_r);
   assign mm_tick = mm_tmr_r == 8'(MM_CYCLES - 1);
   assign mm_fail = mon_en_r[MON_MM_BIT] & mm_tick & ~mm_store & (mm_now != mm_ref_r);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mm_ref_r <= 16'h0000;
         mm_tmr_r <= 8'h00;
         mm_en_d_r <= 1'b0;
         wr_d_r <= 1'b0;
      end else begin
         mm_en_d_r <= mon_en_r[MON_MM_BIT];
         wr_d_r <= wr_fire;
         mm_tmr_r <= (mm_tick || !mon_en_r[MON_MM_BIT]) ? 8'h00 : mm_tmr_r + 8'h01;
         if (mm_store) begin
            mm_ref_r <= mm_now;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mon_err_r <= 8'h00;
      end else begin
         mon_err_r <= ((mon_err_r & ~w1c_err) | {2'b00, ext_fault_pulse, intf_fail, mm_fail, rom_fail})
            & mon_en_r & MON_IMPL_MASK;
      end
   end

   // --------------------
   // Serial readout
   // --------------------
   logic [WORD_W-1:0] results_r [CHANNELS];
   logic [WORD_W-1:0] snap_r [CHANNELS];
   logic [15:0] reg_word_r, crc_a_r, crc_b_r;
   demc_tx_type tx_state_r;
   logic [4:0] tx_bit_r, ch_last_bit;
   logic [2:0] tx_ch_r, ch_count_max;
   logic emit_r, emit, bit_a, bit_b, tx_last_crc;
   logic [23:0] frame_a, frame_b;
   logic [2:0] ch_b;

   function automatic logic [23:0] chan_frame(input logic [WORD_W-1:0] s, input logic [2:0] ch);
      return {s, rst_det_r, digital_error, 1'b0, over_r[ch], under_r[ch], ch};
   endfunction

   assign ch_b = tx_ch_r + 3'h4;
   assign frame_a = reg_mode_r ? {reg_word_r, 8'h00} : chan_frame(snap_r[tx_ch_r], tx_ch_r);
   assign frame_b = chan_frame(snap_r[ch_b], ch_b);
   assign ch_last_bit = reg_mode_r ? 5'(CMD_BITS - 1) :
      5'((status_header_on ? SAMPLE_BITS + HEADER_BITS : SAMPLE_BITS) - 1);
   assign ch_count_max = (reg_mode_r || serial_two_lines) ? 3'h3 : 3'h7;
   assign tx_last_crc = tx_bit_r == 5'(reg_mode_r ? CRC8_BITS - 1 : CRC16_BITS - 1);
   assign emit = emit_r | (in_frame & sclk_rise);
   assign bit_a = (tx_state_r == DEMC_TX_DATA) ? frame_a[5'd23 - tx_bit_r] :
      (tx_state_r == DEMC_TX_CRC) ? (reg_mode_r ? crc_a_r[7] : crc_a_r[15]) : 1'b0;
   assign bit_b = (tx_state_r == DEMC_TX_DATA) ? frame_b[5'd23 - tx_bit_r] :
      (tx_state_r == DEMC_TX_CRC) ? crc_b_r[15] : 1'b0;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         emit_r <= 1'b0;
         tx_state_r <= DEMC_TX_DONE;
         tx_bit_r <= 5'h00;
         tx_ch_r <= 3'h0;
         crc_a_r <= 16'h0000;
         crc_b_r <= 16'h0000;
         reg_word_r <= 16'h0000;
         serial_result_line_first <= 1'b0;
         serial_result_line_second <= 1'b0;
         for (int i = 0; i < CHANNELS; i++) begin
            snap_r[i] <= '0;
         end
      end else begin
         emit_r <= cs_fall;
         if (cs_fall) begin
            snap_r <= results_r;
            reg_word_r <= {2'b00, rd_addr_r, rd_data};
            tx_state_r <= DEMC_TX_DATA;
            tx_bit_r <= 5'h00;
            tx_ch_r <= 3'h0;
            crc_a_r <= 16'h0000;
            crc_b_r <= 16'h0000;
         end else if (emit) begin
            serial_result_line_first <= bit_a;
            serial_result_line_second <= bit_b & serial_two_lines & ~reg_mode_r;
            if (tx_state_r == DEMC_TX_DATA) begin
               if (reg_mode_r) begin
                  crc_a_r <= {8'h00, crc_a_r[6:0], 1'b0} ^ ((crc_a_r[7] ^ bit_a) ? {8'h00, POLY8} : 16'h0000);
               end else begin
                  crc_a_r <= crc16_bits(crc_a_r, {bit_a, 15'h0000}, 1);
                  crc_b_r <= crc16_bits(crc_b_r, {bit_b, 15'h0000}, 1);
               end
               tx_bit_r <= (tx_bit_r == ch_last_bit) ? 5'h00 : tx_bit_r + 5'h01;
               if (tx_bit_r == ch_last_bit) begin
                  if (reg_mode_r || tx_ch_r == ch_count_max) begin
                     tx_state_r <= crc_on ? DEMC_TX_CRC : DEMC_TX_DONE;
                  end else begin
                     tx_ch_r <= tx_ch_r + 3'h1;
                  end
               end
            end else if (tx_state_r == DEMC_TX_CRC) begin
               crc_a_r <= {crc_a_r[14:0], 1'b0};
               crc_b_r <= {crc_b_r[14:0], 1'b0};
               tx_bit_r <= tx_bit_r + 5'h01;
               if (tx_last_crc) begin
                  tx_state_r <= DEMC_TX_DONE;
               end
            end
         end else if (!in_frame) begin
            serial_result_line_first <= 1'b0;
            serial_result_line_second <= 1'b0;
         end
      end
   end

   // --------------------
   // Parallel readout through a small buffer
   // --------------------
   // Two entries absorb one stalled word while the next arrives
   logic [WORD_W-1:0] buf_r [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic [2:0] ch_in_r, ch_out_r;
   logic [15:0] par_crc_r;
   demc_drain_type drain_r;
   logic push, pop;

   assign sample_ready = count_r != CNT_W'(BUF_DEPTH);
   assign push = sample_valid & sample_ready;
   assign pop = (drain_r == DEMC_DRAIN_DATA) & (count_r != '0) & parallel_ready;
   assign parallel_valid = (drain_r == DEMC_DRAIN_CRC) | (count_r != '0);
   assign parallel_bus_word = (drain_r == DEMC_DRAIN_CRC) ? WORD_W'(par_crc_r) : buf_r[rd_ptr_r];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ch_in_r <= 3'h0;
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_r[i] <= '0;
         end
         for (int i = 0; i < CHANNELS; i++) begin
            results_r[i] <= '0;
         end
      end else begin
         if (push) begin
            buf_r[wr_ptr_r] <= sample_word;
            results_r[ch_in_r] <= sample_word;
            wr_ptr_r <= (wr_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            ch_in_r <= ch_in_r + 3'h1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drain_r <= DEMC_DRAIN_DATA;
         ch_out_r <= 3'h0;
         par_crc_r <= 16'h0000;
      end else begin
         case (drain_r)
            DEMC_DRAIN_DATA: begin
               if (pop) begin
                  ch_out_r <= ch_out_r + 3'h1;
                  if (ch_out_r == 3'h7) begin
                     par_crc_r <= crc_on ? crc16_bits(par_crc_r, 16'(buf_r[rd_ptr_r]), WORD_W) : 16'h0000;
                     drain_r <= crc_on ? DEMC_DRAIN_CRC : DEMC_DRAIN_DATA;
                  end else begin
                     par_crc_r <= crc16_bits(par_crc_r, 16'(buf_r[rd_ptr_r]), WORD_W);
                  end
               end
            end
            DEMC_DRAIN_CRC: begin
               if (parallel_ready) begin
                  drain_r <= DEMC_DRAIN_DATA;
                  par_crc_r <= 16'h0000;
               end
            end
            default: begin
               drain_r <= DEMC_DRAIN_DATA;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== test_diag_error_monitor_crc.sv
// Bench: registers over the serial link, samples over the stream ports.
// Assumes the host model demc_host and a 50 MHz ref_clk.
`default_nettype none
module test_diag_error_monitor_crc import demc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic partial_reset_in = 1'b0;
   logic [7:0] over_limit_in = 8'h00;
   logic [7:0] under_limit_in = 8'h00;
   logic [2:0] ext_fault_pulse = 3'h0;
   logic sample_valid = 1'b0;
   logic parallel_ready = 1'b0;
   logic [15:0] sample_word = 16'h0000;
   logic spi_sclk, spi_cs_n, spi_sdi, line_a, line_b, register_mode, sample_ready, parallel_valid;
   logic [15:0] parallel_bus_word, crc;
   logic [7:0] d, c;
   logic [23:0] rx;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   diag_error_monitor_crc DUT (.ref_clk, .rst, .partial_reset_in, .over_limit_in, .under_limit_in,
      .ext_fault_pulse, .status_header_on(1'b0), .serial_two_lines(1'b1), .spi_sclk, .spi_cs_n, .spi_sdi,
      .serial_result_line_first(line_a), .serial_result_line_second(line_b), .register_mode, .sample_word,
      .sample_valid, .sample_ready, .parallel_bus_word, .parallel_valid, .parallel_ready);
   demc_host host (.ref_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .sdo(line_a));
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      host.rd(a, d, c);
      chk(d, exp);
   endtask
   function automatic logic [15:0] crc16(input logic [15:0] c0, input logic [15:0] w);
      logic [15:0] r;
      r = c0;
      for (int i = 15; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? POLY16 : 16'h0000);
      end
      return r;
   endfunction
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rdc(6'h01, 8'h80);
      rdc(6'h01, 8'h00);
      rdc(6'h21, 8'h01);
      rdc(6'h22, 8'h00);
      rdc(6'h10, 8'h00);
      partial_reset_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      partial_reset_in <= 1'b0;
      rdc(6'h01, 8'h80);
      over_limit_in <= 8'h05;
      rdc(6'h26, 8'h00);
      host.wr(6'h25, 8'hFF, 1'b0);
      under_limit_in <= 8'h42;
      repeat (4) @(posedge ref_clk);
      over_limit_in <= 8'h00;
      under_limit_in <= 8'h00;
      rdc(6'h26, 8'h05);
      rdc(6'h27, 8'h42);
      host.wr(6'h26, 8'h01, 1'b0);
      rdc(6'h26, 8'h04);
      host.wr(6'h25, 8'h00, 1'b0);
      rdc(6'h27, 8'h00);
      host.wr(6'h21, 8'h3B, 1'b0);
      ext_fault_pulse <= 3'h1;
      @(posedge ref_clk);
      ext_fault_pulse <= 3'h0;
      rdc(6'h22, 8'h08);
      rdc(6'h01, 8'h40);
      host.wr(6'h22, 8'h08, 1'b0);
      repeat (450) @(posedge ref_clk);
      rdc(6'h22, 8'h00);
      rdc(6'h01, 8'h00);
      host.wr(6'h21, 8'h3F, 1'b0);
      host.crc_on = 1'b1;
      host.rd(6'h21, d, c);
      chk(d, 8'h3F);
      chk(c, host.crc8({2'b00, 6'h21, 8'h3F}));
      host.wr(6'h25, 8'h0F, 1'b1);
      rdc(6'h25, 8'h00);
      rdc(6'h22, 8'h04);
      host.wr(6'h00, 8'h00, 1'b0);
      chk({7'h00, register_mode}, 8'h00);
      crc = 16'h0000;
      fork
         begin
            for (int i = 0; i < 8; i++) begin
               sample_word <= {4{4'(i + 1)}};
               sample_valid <= 1'b1;
               @(negedge ref_clk);
               while (!sample_ready) @(negedge ref_clk);
               @(posedge ref_clk);
            end
            sample_valid <= 1'b0;
         end
         begin
            repeat (12) @(negedge ref_clk);
            chk({7'h00, sample_ready}, 8'h00);
            for (int k = 0; k < 9; k++) begin
               @(posedge ref_clk);
               parallel_ready <= 1'b1;
               @(negedge ref_clk);
               while (!parallel_valid) @(negedge ref_clk);
               chkw(parallel_bus_word, k < 8 ? {4{4'(k + 1)}} : crc);
               crc = crc16(crc, {4{4'(k + 1)}});
               @(posedge ref_clk);
               parallel_ready <= 1'b0;
            end
         end
      join
      host.frame(16'hFFFF, 1'b0, rx);
      chkw(rx[23:8], 16'h1111);
      chk(rx[7:0], 8'h22);
      summarize();
   end
endmodule
`default_nettype wire
